// ### design/spwm_consts.svh
// Constants of the six-bit pulse modulator and its control register.
// Assumes an 8-bit CPU bus with byte addresses and a 10 MHz oscillator clock.
`ifndef SPWM_CONSTS_SVH
`define SPWM_CONSTS_SVH

`define SPWM_ADDR_DUTY    8'h20
`define SPWM_ADDR_MISC    8'h21
`define SPWM_MISC_SPEED   1
`define SPWM_MISC_ENABLE  0
`define SPWM_DIV_SLOW     6'h27
`define SPWM_DIV_FAST     6'h04
`define SPWM_PERIOD_LAST  6'h3f
`define SPWM_ZERO6        6'h00

`endif

// ### design/spwm_pkg.sv
// Types of the six-bit pulse modulator.
// Assumes the constants header is compiled alongside.
package spwm_pkg;
  typedef logic [7:0] spwm_byte_t;
  typedef logic [5:0] spwm_cnt_t;
endpackage

// ### design/spwm_busdiv.sv
// Bus-cycle enable divider for the pulse modulator.
// Assumes a free-running oscillator clock; a stopped clock freezes all state.
`timescale 1ns/100ps
`include "spwm_consts.svh"
module spwm_busdiv (
  // Clock and reset
  input  wire logic             mclk,
  input  wire logic             rst_b,
  // Control
  input  wire logic             slow,
  // Enable out
  output logic                  bus_tick
);
  import spwm_pkg::*;

  typedef struct packed {
    spwm_cnt_t cnt;
    logic      tick;
  } spwm_div_st_t;

  spwm_div_st_t st;
  spwm_div_st_t next_st;

  always_comb begin
    next_st = st;
    next_st.tick = 1'b0;
    // Divide by 40 or 5 from the oscillator
    if (st.cnt >= (slow ? `SPWM_DIV_SLOW : `SPWM_DIV_FAST)) begin
      next_st.cnt  = `SPWM_ZERO6;
      next_st.tick = 1'b1;
    end else begin
      next_st.cnt = st.cnt + 6'h01;
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign bus_tick = st.tick;
endmodule

// ### design/spwm_top.sv
// Six-bit pulse modulator with the miscellaneous control register.
// Assumes a synchronous CPU byte bus on mclk; a stopped mclk is stop mode.
`timescale 1ns/100ps
`include "spwm_consts.svh"
module spwm_top (
  // Clock and reset
  input  wire logic             mclk,
  input  wire logic             rst_b,
  // CPU bus
  input  wire logic [7:0]       cpu_addr,
  input  wire spwm_pkg::spwm_byte_t cpu_wdata,
  input  wire logic             cpu_wr,
  input  wire logic             cpu_rd,
  output spwm_pkg::spwm_byte_t  cpu_rdata,
  // Port logic for the shared pin
  input  wire logic             port_c_bit_seven_out,
  input  wire logic             port_c_bit_seven_oe_b,
  // Shared pin
  output logic                  pin_out,
  output logic                  pin_oe_b,
  // Bus rate enable
  output logic                  bus_tick
);
  import spwm_pkg::*;

  // ****************************************
  // State
  // ****************************************
  typedef struct packed {
    spwm_byte_t duty_hold;
    spwm_byte_t pulse_duty_value;
    logic       pulse_unit_enable;
    logic       speed;
    spwm_cnt_t  cnt;
    logic       sync_low;
    logic       wave;
    spwm_byte_t rdata;
    logic       pout;
    logic       poe_b;
  } spwm_st_t;

  spwm_st_t st;
  spwm_st_t next_st;
  logic     tick;

  // Bus cycles run during wait; a stopped mclk or a low rst_b halts them
  spwm_busdiv u_div (
    .mclk     (mclk),
    .rst_b    (rst_b),
    .slow     (st.speed),
    .bus_tick (tick)
  );

  // ****************************************
  // Next state
  // ****************************************
  always_comb begin
    next_st = st;
    // Modulator clocked only while enabled
    if (st.pulse_unit_enable && tick) begin
      if (st.sync_low) begin
        next_st.sync_low = 1'b0;
        next_st.wave     = 1'b0;
        next_st.cnt      = `SPWM_ZERO6;
      end else begin
        next_st.cnt = st.cnt + 6'h01;
        if (st.cnt == `SPWM_PERIOD_LAST) begin
          next_st.pulse_duty_value = st.duty_hold;
          next_st.wave = (st.duty_hold[5:0] != `SPWM_ZERO6);
        end else if (next_st.cnt == st.pulse_duty_value[5:0]) begin
          next_st.wave = 1'b0;
        end else if (st.cnt == `SPWM_ZERO6 && st.wave == 1'b0
                     && st.pulse_duty_value[5:0] != `SPWM_ZERO6
                     && next_st.cnt == 6'h01) begin
          next_st.wave = 1'b1;
        end
      end
    end
    if (cpu_wr) begin
      case (cpu_addr)
        `SPWM_ADDR_DUTY: begin
          next_st.duty_hold = cpu_wdata;
          if (!st.pulse_unit_enable) begin
            next_st.pulse_duty_value = cpu_wdata;
          end
        end
        `SPWM_ADDR_MISC: begin
          next_st.speed = cpu_wdata[`SPWM_MISC_SPEED];
          next_st.pulse_unit_enable = cpu_wdata[`SPWM_MISC_ENABLE];
          if (cpu_wdata[`SPWM_MISC_ENABLE] && !st.pulse_unit_enable) begin
            next_st.sync_low = 1'b1;
            next_st.wave     = 1'b0;
          end
        end
        default: begin
        end
      endcase
    end
    next_st.rdata = 8'h00;
    if (cpu_rd) begin
      case (cpu_addr)
        `SPWM_ADDR_DUTY: next_st.rdata = st.pulse_duty_value;
        `SPWM_ADDR_MISC: begin
          next_st.rdata[`SPWM_MISC_SPEED]  = st.speed;
          next_st.rdata[`SPWM_MISC_ENABLE] = st.pulse_unit_enable;
        end
        default: next_st.rdata = 8'h00;
      endcase
    end
    // Pin handover between modulator and port logic
    if (next_st.pulse_unit_enable) begin
      next_st.pout  = next_st.wave;
      next_st.poe_b = 1'b0;
    end else begin
      next_st.pout  = port_c_bit_seven_out;
      next_st.poe_b = port_c_bit_seven_oe_b;
    end
  end

  // ****************************************
  // Registers
  // ****************************************
  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      st       <= '0;
      st.poe_b <= 1'b1;
    end else begin
      st <= next_st;
    end
  end

  assign cpu_rdata = st.rdata;
  assign pin_out   = st.pout;
  assign pin_oe_b  = st.poe_b;
  assign bus_tick  = tick;
endmodule

// ### testbench/spwm_properties.sv
// Port checker for the pulse modulator.
// Assumes the enable is misc bit 0.
`timescale 1ns/100ps
module spwm_properties (
  input wire logic       mclk,
  input wire logic       rst_b,
  input wire logic [7:0] cpu_addr,
  input wire logic [7:0] cpu_wdata,
  input wire logic       cpu_wr,
  input wire logic       cpu_rd,
  input wire logic [7:0] cpu_rdata,
  input wire logic       port_c_bit_seven_out,
  input wire logic       port_c_bit_seven_oe_b,
  input wire logic       pin_out,
  input wire logic       pin_oe_b,
  input wire logic       bus_tick
);
  logic en;
  always_ff @(posedge mclk)
    en <= !rst_b ? 1'b0 : cpu_wr && cpu_addr == 8'h21 ? cpu_wdata[0] : en;
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_b);
  rd_idle_a: assert property (!$past(cpu_rd) |-> !cpu_rdata) else $error("rdata");
  rst_pin_a: assert property (disable iff (1'b0) !rst_b |=> pin_oe_b) else $error("rst");
  tick_gap_a: assert property (bus_tick |=> !bus_tick [*4]) else $error("tick");
  tick_max_a: assert property (bus_tick |-> ##[1:40] bus_tick) else $error("tick");
  misc_rd_a: assert property (cpu_rd && cpu_addr == 8'h21 |=> cpu_rdata[0] == $past(en))
    else $error("misc");
  pin_drv_a: assert property (en |-> !pin_oe_b) else $error("drive");
  pin_port_a: assert property (!en && !$past(en) |->
    pin_oe_b == $past(port_c_bit_seven_oe_b)) else $error("port");
  sync_low_a: assert property ($rose(en) |-> !pin_out [*5]) else $error("sync");
endmodule
bind spwm_top spwm_properties i_chk (.*);

// ### testbench/spwm_load.sv
// Load on the shared pin.
// Assumes no pull-up, so a released pin floats.
`timescale 1ns/100ps
module spwm_load (
  input wire logic mclk,
  input wire logic pin_out,
  input wire logic pin_oe_b,
  output logic     lvl
);
  logic last = 1'b0;
  always @(posedge mclk) last <= lvl;
  assign lvl = pin_oe_b ? ~last : pin_out;
endmodule

// ### testbench/test_six_bit_pwm_with_misc_control.sv
// Bench for the pulse modulator.
// Assumes misc bit 0 enable, bit 1 speed.
`timescale 1ns/100ps
module test_six_bit_pwm_with_misc_control;
  logic mclk = 0, rst_b = 0, cpu_wr = 0, cpu_rd = 0, rd_q = 0, pin_out, pin_oe_b, lvl;
  logic port_c_bit_seven_out = 0, port_c_bit_seven_oe_b = 1, bus_tick;
  logic [7:0] cpu_addr = 0, cpu_wdata = 0, cpu_rdata, d, v[3], exp_q[$];
  int   fail_count = 0, checked = 0, n;
  spwm_top i_dut (.*);
  spwm_load i_load (.*);
  task automatic cmp(string s, logic [7:0] e, logic [7:0] g);
    checked++;
    fail_count += (g !== e);
    if (g !== e) $display("ERROR %s exp %h got %h", s, e, g);
  endtask
  task automatic op(logic w, logic [7:0] a, logic [7:0] x);
    @(posedge mclk) #10 {cpu_wr, cpu_rd, cpu_addr, cpu_wdata} = {w, !w, a, x};
    if (!w) exp_q.push_back(x);
    @(posedge mclk) #10 {cpu_wr, cpu_rd} = 2'b00;
  endtask
  task automatic end_of_test;
    if (fail_count == 0 && checked > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  always @(posedge mclk) rd_q <= cpu_rd;
  always @(posedge mclk) if (rd_q) cmp("rdata", exp_q.pop_front(), cpu_rdata);
  initial forever #50 mclk = ~mclk;
  initial begin
    repeat (20000) @(posedge mclk);
    fail_count++;
    end_of_test;
  end
  initial begin
    n = $urandom(32'h4c5e9728);
    d = 8'($urandom);
    v = '{8'($urandom), 8'h00, 8'h3f};
    #760 rst_b = 1;
    op(0, 8'h21, 8'h00);
    op(1, 8'h20, d);
    op(0, 8'h20, d);
    op(1, 8'h21, 8'h01);
    foreach (v[i]) begin
      // Write just after a tick so no period boundary splits write and read
      @(posedge mclk iff bus_tick);
      op(1, 8'h20, v[i]);
      op(0, 8'h20, d);
      repeat (130) @(posedge mclk iff bus_tick);
      d = v[i];
      op(0, 8'h20, d);
      n = 0;
      repeat (64) @(posedge mclk iff bus_tick) n += lvl;
      cmp("high", {2'b00, d[5:0]}, 8'(n));
    end
    // Port logic gets the pin back while the unit is off
    port_c_bit_seven_out = 1'($urandom);
    port_c_bit_seven_oe_b = 1'($urandom);
    op(1, 8'h21, 8'h00);
    @(posedge mclk);
    cmp("pin", {6'h00, port_c_bit_seven_oe_b, port_c_bit_seven_out}, {6'h00, pin_oe_b, pin_out});
    op(1, 8'h21, 8'h03);
    cmp("pin", 8'h00, {6'h00, pin_oe_b, pin_out});
    repeat (2) @(posedge mclk iff bus_tick);
    repeat (40) @(posedge mclk);
    cmp("tick", 8'h01, {7'h00, bus_tick});
    end_of_test;
  end
endmodule
